//--- common/rtc_params.svh
// Constants for the counter and tick timer register block
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
// =====================================================================
// Register indices (byte address is four times the index)
`define IDX_CTRL 5'h00
`define IDX_BUSY 5'h01
`define IDX_IEN 5'h02
`define IDX_IFLG 5'h03
`define IDX_TEMP 5'h04
`define IDX_HALT 5'h05
`define IDX_CRYSTAL_CORRECTION 5'h06
`define IDX_SOURCE_SELECT 5'h07
`define IDX_CNT_L 5'h08
`define IDX_CNT_H 5'h09
`define IDX_TOP_L 5'h0A
`define IDX_TOP_H 5'h0B
`define IDX_CMP_L 5'h0C
`define IDX_CMP_H 5'h0D
`define IDX_TCTL 5'h10
`define IDX_TBUSY 5'h11
`define IDX_TIEN 5'h12
`define IDX_TIFLG 5'h13
`define IDX_THALT 5'h15
// =====================================================================
// Field positions
`define CTL_ON 0
`define CTL_CORR 2
`define CTL_DIV_LO 3
`define CTL_DIV_HI 6
`define CTL_STBY 7
`define TCTL_ON 0
`define TCTL_PER_LO 3
`define TCTL_PER_HI 6
`define CH_CTL 0
`define CH_CNT 1
`define CH_TOP 2
`define CH_CMP 3
`define CH_TICK 4
`define CH_NUM 5
`define IRQ_WRAP 0
`define IRQ_MATCH 1
`define HALT_RUN 0
// =====================================================================
// Masks, reset values, sync timing
`define CTRL_MASK 8'hFD
`define TCTL_MASK 8'h79
`define TOP_RESET 16'hFFFF
`define SYNC_LAST 1'h1
`endif

//--- common/rtc_pkg.sv
// Types shared by the counter and tick timer register block
package rtc_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage

//--- hdl/rtc_pit_sync_regs.sv
// Counter and tick timer with APB registers and slow-clock sync
`timescale 1ns/100ps
`include "rtc_params.svh"

module rtc_pit_sync_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // APB slave
  input wire rtc_pkg::apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and system state
  input wire logic slow_clk_pin,
  input wire logic cpu_halted,
  input wire logic standby_sleep,
  // Outputs
  output logic rtc_irq,
  output logic tick_irq,
  output logic tick_out,
  output logic wrap_event,
  output logic match_event,
  output logic drift_fix_on,
  output logic [1:0] clk_source
);

  // ===================================================================
  // Slow clock sampling
  logic sc1_q, sc2_q, sc3_q;
  logic slow_edge;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sc1_q <= 1'b0;
      sc2_q <= 1'b0;
      sc3_q <= 1'b0;
    end
    else
    begin
      sc1_q <= slow_clk_pin;
      sc2_q <= sc1_q;
      sc3_q <= sc2_q;
    end
  end

  // Rising edge is found between the second and third stages
  assign slow_edge = sc2_q & ~sc3_q;

  // ===================================================================
  // APB decode
  logic [4:0] idx;
  logic access, done, wr_ok, rd_ok, mapped;
  logic [7:0] wd;

  assign idx = apb_req.paddr[6:2];
  assign wd = apb_req.pwdata[7:0];
  assign access = apb_req.psel & apb_req.penable;
  assign done = access & pready;
  assign wr_ok = done & apb_req.pwrite & mapped;
  assign rd_ok = done & ~apb_req.pwrite & mapped;

  always_comb
  begin
    mapped = 1'b0;
    if (!apb_req.paddr[7] && apb_req.paddr[1:0] == 2'h0)
    begin
      unique case (idx)
        `IDX_CTRL, `IDX_BUSY, `IDX_IEN, `IDX_IFLG, `IDX_TEMP, `IDX_HALT,
        `IDX_CRYSTAL_CORRECTION, `IDX_SOURCE_SELECT, `IDX_CNT_L, `IDX_CNT_H, `IDX_TOP_L,
        `IDX_TOP_H, `IDX_CMP_L, `IDX_CMP_H, `IDX_TCTL, `IDX_TBUSY,
        `IDX_TIEN, `IDX_TIFLG, `IDX_THALT: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  // ===================================================================
  // Bus-side registers
  logic [7:0] ctl_q, tctl_q, temp_q, crystal_correction_q;
  logic [15:0] cnt_wr_q, top_q, cmp_q;
  logic [1:0] irq_en_q, source_select_q;
  logic tick_en_q, halt_q, tick_halt_q;
  logic [`CH_NUM-1:0] written, apply, busy_q;
  logic [15:0] cnt_q;

  always_comb
  begin
    written = '0;
    written[`CH_CTL] = wr_ok && idx == `IDX_CTRL;
    written[`CH_CNT] = wr_ok && idx == `IDX_CNT_H;
    written[`CH_TOP] = wr_ok && idx == `IDX_TOP_H;
    written[`CH_CMP] = wr_ok && idx == `IDX_CMP_H;
    written[`CH_TICK] = wr_ok && idx == `IDX_TCTL;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctl_q <= 8'h00;
      tctl_q <= 8'h00;
      irq_en_q <= 2'h0;
      tick_en_q <= 1'b0;
      halt_q <= 1'b0;
      tick_halt_q <= 1'b0;
      crystal_correction_q <= 8'h00;
      source_select_q <= 2'h0;
    end
    else if (wr_ok)
    begin
      unique case (idx)
        `IDX_CTRL: ctl_q <= wd & `CTRL_MASK;
        `IDX_TCTL: tctl_q <= wd & `TCTL_MASK;
        `IDX_IEN: irq_en_q <= wd[1:0];
        `IDX_TIEN: tick_en_q <= wd[0];
        `IDX_HALT: halt_q <= wd[`HALT_RUN];
        `IDX_THALT: tick_halt_q <= wd[`HALT_RUN];
        `IDX_CRYSTAL_CORRECTION: crystal_correction_q <= wd;
        `IDX_SOURCE_SELECT: source_select_q <= wd[1:0];
        default: ;
      endcase
    end
  end

  // Shared byte latch pairs the halves of every 16-bit value
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      temp_q <= 8'h00;
      cnt_wr_q <= 16'h0000;
      top_q <= `TOP_RESET;
      cmp_q <= 16'h0000;
    end
    else if (wr_ok)
    begin
      unique case (idx)
        `IDX_TEMP, `IDX_CNT_L, `IDX_TOP_L, `IDX_CMP_L: temp_q <= wd;
        `IDX_CNT_H: cnt_wr_q <= {wd, temp_q};
        `IDX_TOP_H: top_q <= {wd, temp_q};
        `IDX_CMP_H: cmp_q <= {wd, temp_q};
        default: ;
      endcase
    end
    else if (rd_ok)
    begin
      unique case (idx)
        `IDX_CNT_L: temp_q <= cnt_q[15:8];
        `IDX_TOP_L: temp_q <= top_q[15:8];
        `IDX_CMP_L: temp_q <= cmp_q[15:8];
        default: ;
      endcase
    end
  end

  // ===================================================================
  // Crossing channels: busy until second slow edge captures
  logic [`CH_NUM-1:0] stage_q;

  for (genvar i = 0; i < `CH_NUM; i++)
  begin : g_sync
    // Software must not rewrite while busy; a rewrite restarts the crossing
    assign apply[i] = busy_q[i] & slow_edge & (stage_q[i] == `SYNC_LAST) & ~written[i];

    always_ff @(posedge core_clk or negedge nrst)
    begin
      if (!nrst)
      begin
        busy_q[i] <= 1'b0;
        stage_q[i] <= 1'b0;
      end
      else if (written[i])
      begin
        busy_q[i] <= 1'b1;
        stage_q[i] <= 1'b0;
      end
      else if (busy_q[i] && slow_edge)
      begin
        busy_q[i] <= stage_q[i] != `SYNC_LAST;
        stage_q[i] <= ~stage_q[i];
      end
    end
  end

  // ===================================================================
  // Slow-side copies
  logic [7:0] ctl_eff_q, tctl_eff_q;
  logic [15:0] top_eff_q, cmp_eff_q;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctl_eff_q <= 8'h00;
      tctl_eff_q <= 8'h00;
      top_eff_q <= `TOP_RESET;
      cmp_eff_q <= 16'h0000;
    end
    else
    begin
      if (apply[`CH_CTL])
        ctl_eff_q <= ctl_q;
      if (apply[`CH_TICK])
        tctl_eff_q <= tctl_q;
      if (apply[`CH_TOP])
        top_eff_q <= top_q;
      if (apply[`CH_CMP])
        cmp_eff_q <= cmp_q;
    end
  end

  // ===================================================================
  // Prescaler and counter
  logic [14:0] presc_q, div_mask;
  logic [3:0] div_sel, per_sel;
  logic rtc_on, tick_on, rtc_frozen, tick_gate, rtc_step, wrap_hit, match_hit;

  assign div_sel = ctl_eff_q[`CTL_DIV_HI:`CTL_DIV_LO];
  assign rtc_on = ctl_eff_q[`CTL_ON];
  assign tick_on = tctl_eff_q[`TCTL_ON];
  assign div_mask = 15'((16'h0001 << div_sel) - 16'h0001);
  assign rtc_frozen = (cpu_halted & ~halt_q)
    | (standby_sleep & ~ctl_eff_q[`CTL_STBY]);
  assign tick_gate = ~(cpu_halted & ~tick_halt_q);
  assign rtc_step = slow_edge & rtc_on & ~rtc_frozen & ((presc_q & div_mask) == div_mask);
  assign wrap_hit = rtc_step & (cnt_q == top_eff_q);
  assign match_hit = rtc_step & (cnt_q == cmp_eff_q);

  // Shared prescaler halts only when every enabled user is halted
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      presc_q <= 15'h0000;
    else if (!rtc_on && !tick_on)
      presc_q <= 15'h0000;
    else if (slow_edge && ((rtc_on && !rtc_frozen) || (tick_on && tick_gate)))
      presc_q <= presc_q + 15'h0001;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      cnt_q <= 16'h0000;
    else if (apply[`CH_CNT])
      cnt_q <= cnt_wr_q;
    else if (wrap_hit)
      cnt_q <= 16'h0000;
    else if (rtc_step)
      cnt_q <= cnt_q + 16'h0001;
  end

  // ===================================================================
  // Ticker output
  logic tick_level;

  assign per_sel = tctl_eff_q[`TCTL_PER_HI:`TCTL_PER_LO];
  assign tick_level = tick_on & (per_sel != 4'h0) & presc_q[4'(per_sel - 4'h1)] & tick_gate;

  // ===================================================================
  // Flags and requests
  logic [1:0] irq_flag_q, irq_flag_d, irq_clr;
  logic tick_flag_q, tick_flag_d, tick_clr, tick_rise;

  assign tick_rise = tick_level & ~tick_out;
  assign irq_clr = (wr_ok && idx == `IDX_IFLG) ? wd[1:0] : 2'h0;
  assign tick_clr = wr_ok && idx == `IDX_TIFLG && wd[0];
  // Set beats a clear arriving in the same cycle
  assign irq_flag_d[`IRQ_WRAP] = wrap_hit | (irq_flag_q[`IRQ_WRAP] & ~irq_clr[`IRQ_WRAP]);
  assign irq_flag_d[`IRQ_MATCH] = match_hit | (irq_flag_q[`IRQ_MATCH] & ~irq_clr[`IRQ_MATCH]);
  assign tick_flag_d = tick_rise | (tick_flag_q & ~tick_clr);

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_flag_q <= 2'h0;
      tick_flag_q <= 1'b0;
      tick_out <= 1'b0;
      wrap_event <= 1'b0;
      match_event <= 1'b0;
    end
    else
    begin
      irq_flag_q <= irq_flag_d;
      tick_flag_q <= tick_flag_d;
      tick_out <= tick_level;
      wrap_event <= wrap_hit;
      match_event <= match_hit;
    end
  end

  // Requests track flags and enables of the same cycle
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rtc_irq <= 1'b0;
      tick_irq <= 1'b0;
      drift_fix_on <= 1'b0;
      clk_source <= 2'h0;
    end
    else
    begin
      rtc_irq <= |(irq_flag_d & ((wr_ok && idx == `IDX_IEN) ? wd[1:0] : irq_en_q));
      tick_irq <= tick_flag_d & ((wr_ok && idx == `IDX_TIEN) ? wd[0] : tick_en_q);
      drift_fix_on <= ctl_eff_q[`CTL_CORR];
      clk_source <= source_select_q;
    end
  end

  // ===================================================================
  // Read mux and APB answer (one wait state)
  logic [7:0] rd_mux;

  always_comb
  begin
    rd_mux = 8'h00;
    unique case (idx)
      `IDX_CTRL: rd_mux = ctl_q;
      `IDX_BUSY: rd_mux = {4'h0, busy_q[`CH_CMP:`CH_CTL]};
      `IDX_IEN: rd_mux = {6'h00, irq_en_q};
      `IDX_IFLG: rd_mux = {6'h00, irq_flag_q};
      `IDX_TEMP, `IDX_CNT_H, `IDX_TOP_H, `IDX_CMP_H: rd_mux = temp_q;
      `IDX_HALT: rd_mux = {7'h00, halt_q};
      `IDX_CRYSTAL_CORRECTION: rd_mux = crystal_correction_q;
      `IDX_SOURCE_SELECT: rd_mux = {6'h00, source_select_q};
      `IDX_CNT_L: rd_mux = cnt_q[7:0];
      `IDX_TOP_L: rd_mux = top_q[7:0];
      `IDX_CMP_L: rd_mux = cmp_q[7:0];
      `IDX_TCTL: rd_mux = tctl_q;
      `IDX_TBUSY: rd_mux = {7'h00, busy_q[`CH_TICK]};
      `IDX_TIEN: rd_mux = {7'h00, tick_en_q};
      `IDX_TIFLG: rd_mux = {7'h00, tick_flag_q};
      `IDX_THALT: rd_mux = {7'h00, tick_halt_q};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      if (access && !pready)
        prdata <= (mapped && !apb_req.pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  // ===================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  ctl_busy_set_a: assert property (written[`CH_CTL] |=> busy_q[`CH_CTL] ##1 busy_q[`CH_CTL])
    else $error("control busy not set by write");
  ctl_capture_a: assert property (apply[`CH_CTL] |=> !busy_q[`CH_CTL] && ctl_eff_q == $past(ctl_q))
    else $error("control not captured at second slow edge");
  tick_busy_a: assert property (written[`CH_TICK] |=> busy_q[`CH_TICK])
    else $error("ticker busy not set by write");
  flag_clear_a: assert property (irq_clr[`IRQ_WRAP] && !wrap_hit |=> !irq_flag_q[`IRQ_WRAP])
    else $error("wrap flag not cleared by one");
  set_wins_a: assert property (wrap_hit |=> irq_flag_q[`IRQ_WRAP])
    else $error("wrap flag lost");
  irq_level_a: assert property (rtc_irq == |(irq_flag_q & irq_en_q))
    else $error("request differs from flag and enable");
  halt_freeze_a: assert property (cpu_halted && !halt_q && !apply[`CH_CNT] |=> $stable(cnt_q))
    else $error("counter moved while halted");
  tick_low_a: assert property (cpu_halted && !tick_halt_q |=> !tick_out)
    else $error("tick output high while halted");
  wrap_zero_a: assert property (wrap_hit && !apply[`CH_CNT] |=> cnt_q == 16'h0000 && irq_flag_q[`IRQ_WRAP])
    else $error("counter did not wrap to zero");
  resume_edge_a: assert property ($rose(tick_out) |-> tick_flag_q)
    else $error("tick rise without flag");

endmodule // rtc_pit_sync_regs

//--- bench/rtc_pit_sync_regs_tb.sv
// Self-checking bench for the counter and tick timer register block
`timescale 1ns/100ps
`include "rtc_params.svh"

module rtc_pit_sync_regs_tb;
  // ==========================================================
  // Signals
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  rtc_pkg::apb_req_t apb_req = '0;
  logic [31:0] prdata;
  logic pready, pslverr, rtc_irq, tick_irq, tick_out;
  logic wrap_event, match_event, drift_fix_on;
  logic [1:0] clk_source;
  logic slow_clk_pin = 1'b0;
  logic cpu_halted = 1'b0;
  logic standby_sleep = 1'b0;
  logic [2:0] sdiv_q = 3'h0;
  logic [7:0] rd;
  logic er;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;

  rtc_pit_sync_regs i_dut (
    .core_clk(core_clk), .nrst(nrst), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .slow_clk_pin(slow_clk_pin),
    .cpu_halted(cpu_halted), .standby_sleep(standby_sleep), .rtc_irq(rtc_irq),
    .tick_irq(tick_irq), .tick_out(tick_out), .wrap_event(wrap_event),
    .match_event(match_event), .drift_fix_on(drift_fix_on), .clk_source(clk_source)
  );

  // ==========================================================
  // Clocks and timeout
  always #50 core_clk = ~core_clk;

  // Slow clock of eight core cycles, well above the two-cycle hold limit
  always @(posedge core_clk)
  begin
    sdiv_q <= sdiv_q + 3'h1;
    slow_clk_pin <= sdiv_q[2];
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      close_out();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Request held until pready is sampled high at a rising edge
  task automatic xfer(input logic w, input logic [4:0] idx, input logic [7:0] d);
    @(posedge core_clk);
    apb_req <= '{1'b1, 1'b0, w, {1'b0, idx, 2'b00}, {24'h0, d}};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata[7:0];
    er = pslverr;
    apb_req <= '0;
  endtask

  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask

  task automatic rchk(input logic [4:0] idx, input logic [7:0] exp, input string nm);
    xfer(1'b0, idx, 8'h00);
    chk(nm, exp, rd);
  endtask

  // Busy must show on the first read and clear within a bounded wait
  task automatic wait_idle(input logic [4:0] idx, input int b);
    xfer(1'b0, idx, 8'h00);
    chk("busy set", 8'h01, 8'(rd[b]));
    for (int i = 0; i < 20 && rd[b] !== 1'b0; i++)
      xfer(1'b0, idx, 8'h00);
    chk("busy clear", 8'h00, 8'(rd[b]));
  endtask

  task automatic gap(output int n);
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wrap_event !== 1'b1 && n < 2000);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rchk(`IDX_CTRL, 8'h00, "control");
    rchk(`IDX_BUSY, 8'h00, "busy");
    rchk(`IDX_TBUSY, 8'h00, "tick busy");
    rchk(`IDX_TOP_L, 8'hFF, "top low");
    rchk(`IDX_TOP_H, 8'hFF, "top high");
    xfer(1'b0, 5'h0E, 8'h00);
    chk("unmapped err", 8'h01, 8'(er));
    wr(`IDX_CRYSTAL_CORRECTION, 8'hA5);
    rchk(`IDX_CRYSTAL_CORRECTION, 8'hA5, "crystal_correction");
    wr(`IDX_SOURCE_SELECT, 8'h03);
    // Output register follows the stored value one edge later
    idle(2);
    chk("source", 8'h03, 8'(clk_source));
  endtask

  task automatic t_setup();
    wr(`IDX_CTRL, 8'h04);
    wait_idle(`IDX_BUSY, 0);
    chk("drift fix", 8'h01, 8'(drift_fix_on));
    wr(`IDX_CNT_L, 8'h00);
    wr(`IDX_CNT_H, 8'h00);
    wait_idle(`IDX_BUSY, 1);
    wr(`IDX_TOP_L, 8'h03);
    wr(`IDX_TOP_H, 8'h00);
    wait_idle(`IDX_BUSY, 2);
    wr(`IDX_CMP_L, 8'h02);
    wr(`IDX_CMP_H, 8'h00);
    wait_idle(`IDX_BUSY, 3);
    rchk(`IDX_TOP_L, 8'h03, "top low");
    rchk(`IDX_TOP_H, 8'h00, "top high");
    wr(`IDX_IEN, 8'h03);
    wr(`IDX_CTRL, 8'h01);
    wait_idle(`IDX_BUSY, 0);
  endtask

  task automatic t_irq();
    int n;
    idle(70);
    rchk(`IDX_IFLG, 8'h03, "flags");
    chk("rtc irq", 8'h01, 8'(rtc_irq));
    gap(n);
    gap(n);
    chk("no_division gap", 8'd32, 8'(n));
    // Compare of 2 is seen at the third step after the wrap
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (match_event !== 1'b1 && n < 2000);
    chk("match lag", 8'd24, 8'(n));
    wr(`IDX_CTRL, 8'h11);
    wait_idle(`IDX_BUSY, 0);
    gap(n);
    gap(n);
    chk("div4 gap", 8'd128, 8'(n));
    wr(`IDX_CTRL, 8'h00);
    wait_idle(`IDX_BUSY, 0);
    wr(`IDX_IFLG, 8'h00);
    rchk(`IDX_IFLG, 8'h03, "write zero");
    wr(`IDX_IFLG, 8'h02);
    rchk(`IDX_IFLG, 8'h01, "clear match");
    wr(`IDX_IFLG, 8'h01);
    idle(2);
    chk("irq dropped", 8'h00, 8'(rtc_irq));
  endtask

  // Row of the halt and standby table: wrap and match seen or frozen
  task automatic frz(input logic h, s, dbg, input logic [7:0] ctl, input logic [7:0] exp);
    wr(`IDX_HALT, 8'(dbg));
    wr(`IDX_CTRL, ctl);
    wait_idle(`IDX_BUSY, 0);
    cpu_halted <= h;
    standby_sleep <= s;
    idle(4);
    wr(`IDX_IFLG, 8'h03);
    idle(48);
    rchk(`IDX_IFLG, exp, "frozen flags");
    cpu_halted <= 1'b0;
    standby_sleep <= 1'b0;
  endtask

  task automatic t_tick();
    wr(`IDX_TIEN, 8'h01);
    wr(`IDX_THALT, 8'h00);
    wr(`IDX_TCTL, 8'h11);
    wait_idle(`IDX_TBUSY, 0);
    for (int i = 0; i < 100 && tick_irq !== 1'b1; i++)
      idle(1);
    chk("tick irq", 8'h01, 8'(tick_irq));
    // Halt just after a rise, so the ticker is surely high when frozen
    for (int i = 0; i < 100 && tick_out !== 1'b0; i++)
      idle(1);
    for (int i = 0; i < 100 && tick_out !== 1'b1; i++)
      idle(1);
    cpu_halted <= 1'b1;
    idle(3);
    chk("forced low", 8'h00, 8'(tick_out));
    wr(`IDX_TIFLG, 8'h01);
    idle(40);
    rchk(`IDX_TIFLG, 8'h00, "no tick halted");
    cpu_halted <= 1'b0;
    idle(3);
    rchk(`IDX_TIFLG, 8'h01, "fresh edge");
    for (int i = 0; i < 100 && tick_out !== 1'b0; i++)
      idle(1);
    cpu_halted <= 1'b1;
    wr(`IDX_TIFLG, 8'h01);
    cpu_halted <= 1'b0;
    idle(2);
    rchk(`IDX_TIFLG, 8'h00, "resume low");
    wr(`IDX_THALT, 8'h01);
    cpu_halted <= 1'b1;
    wr(`IDX_TIFLG, 8'h01);
    idle(40);
    rchk(`IDX_TIFLG, 8'h01, "tick runs");
    cpu_halted <= 1'b0;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    idle(8);
    nrst <= 1'b1;
    t_reset();
    t_setup();
    t_irq();
    frz(1'b1, 1'b0, 1'b0, 8'h01, 8'h00);
    frz(1'b1, 1'b0, 1'b1, 8'h01, 8'h03);
    frz(1'b0, 1'b1, 1'b0, 8'h01, 8'h00);
    frz(1'b0, 1'b1, 1'b0, 8'h81, 8'h03);
    t_tick();
    close_out();
  end
endmodule // rtc_pit_sync_regs_tb
